//--- design/focss_pkg.sv
package focss_pkg;
	localparam int unsigned ADDR_W = 9;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned Q_SHIFT = 15;
	localparam logic [8:0] ADDR_CTRL       = 9'h000;
	localparam logic [8:0] ADDR_SAMPLE_CMP = 9'h004;
	localparam logic [8:0] ADDR_SECTOR     = 9'h008;
	localparam logic [8:0] ADDR_SAT_LIMIT  = 9'h00C;
	localparam logic [8:0] ADDR_SINE       = 9'h010;
	localparam logic [8:0] ADDR_COSINE     = 9'h014;
	localparam logic [8:0] ADDR_VD_REQ     = 9'h018;
	localparam logic [8:0] ADDR_VQ_REQ     = 9'h01C;
	localparam logic [8:0] ADDR_IQD        = 9'h020;
	localparam logic [8:0] ADDR_VAB        = 9'h024;
	localparam logic [8:0] ADDR_STATUS     = 9'h028;
	localparam logic [8:0] ADDR_IAB        = 9'h02C;
	localparam logic [8:0] ADDR_VQD_SAT    = 9'h030;
	localparam int unsigned LUT_SEL_BIT = 8;
	localparam int unsigned LUT_IDX_W = 6;
	localparam int unsigned LUT_DEPTH = 64;
	localparam int unsigned MAG_IDX_LSB = 26;
	localparam int unsigned CTRL_TOPO_LSB = 0;
	localparam int unsigned CTRL_DUAL_BIT = 2;
	localparam int unsigned CTRL_AFTER_BIT = 3;
	localparam int unsigned CTRL_TEN_CLR_BIT = 4;
	localparam logic signed [15:0] WORD_MAX = 16'sh7FFF;
	localparam logic signed [15:0] WORD_MIN = 16'sh8000;
	localparam logic signed [15:0] INV_SQRT3 = 16'sh49E7;
	localparam logic [15:0] SAT_LIMIT_RST = 16'h7FFF;
	localparam logic [15:0] CMP_RST = 16'h0000;
	localparam logic [2:0] SECTOR_RST = 3'h1;
	localparam logic [1:0] TOPO_THREE_SHUNT = 2'h0;
	localparam logic [1:0] TOPO_SINGLE_SHUNT = 2'h1;
	localparam logic [1:0] TOPO_ISOLATED = 2'h2;
	localparam logic [1:0] PAIR_BC = 2'h0;
	localparam logic [1:0] PAIR_AC = 2'h1;
	localparam logic [1:0] PAIR_AB = 2'h2;
	typedef enum logic [1:0] {V_IDLE, V_MAG, V_SCALE, V_ROT} focss_vstate_t;

	function automatic logic signed [15:0] sat16(
		input logic signed [47:0] v
	);
		if (v > 48'(WORD_MAX))
			return WORD_MAX;
		else if (v < 48'(WORD_MIN))
			return WORD_MIN;
		else
			return v[15:0];
	endfunction

	function automatic logic signed [15:0] sat_q15(
		input logic signed [47:0] prod
	);
		return sat16(prod >>> Q_SHIFT);
	endfunction
endpackage

//--- design/focss_rotate.sv
`timescale 1ns/1ps
`default_nettype none
// Computes o1 = x*c - y*s and o2 = x*s + y*c in Q15 with saturation.
module focss_rotate (
	input  wire logic signed [15:0] x,
	input  wire logic signed [15:0] y,
	input  wire logic signed [15:0] c,
	input  wire logic signed [15:0] s,
	output logic signed [15:0]      o1,
	output logic signed [15:0]      o2
);
	logic signed [31:0] xc;
	logic signed [31:0] ys;
	logic signed [31:0] xs;
	logic signed [31:0] yc;
	logic signed [32:0] p1;
	logic signed [32:0] p2;

	assign xc = x * c;
	assign ys = y * s;
	assign xs = x * s;
	assign yc = y * c;
	assign p1 = 33'(xc) - 33'(ys);
	assign p2 = 33'(xs) + 33'(yc);
	assign o1 = focss_pkg::sat_q15(48'(p1));
	assign o2 = focss_pkg::sat_q15(48'(p2));
endmodule // focss_rotate
`default_nettype wire

//--- design/focss_core.sv
`timescale 1ns/1ps
`default_nettype none
module focss_core (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic [8:0]          addr,
	input  wire logic [31:0]         wdata,
	input  wire logic                wr,
	input  wire logic                rd,
	output logic [31:0]              rdata,
	input  wire logic [15:0]         first_timer_count,
	input  wire logic                first_timer_up,
	input  wire logic                first_timer_update_event,
	input  wire logic [15:0]         second_timer_count,
	input  wire logic                second_timer_up,
	input  wire logic                second_timer_update_event,
	input  wire logic                trigger_enable_dma_channel,
	input  wire logic                conv_done,
	input  wire logic signed [15:0]  master_converter_data,
	input  wire logic signed [15:0]  slave_converter_data,
	output logic                     sampling_trigger_channel,
	output logic                     trigger_polarity_bit,
	output logic [15:0]              sampling_compare_value,
	output logic [1:0]               channel_pair,
	output logic                     adc_trigger_enable,
	output logic                     drive_sel,
	output logic signed [15:0]       i_q,
	output logic signed [15:0]       i_d,
	output logic                     currents_valid,
	output logic signed [15:0]       v_alpha,
	output logic signed [15:0]       v_beta,
	output logic                     voltages_valid
);
	localparam int unsigned LUT_DEPTH_L = focss_pkg::LUT_DEPTH;

	logic [1:0]         topology_reg;
	logic               dual_reg;
	logic               after_next_reg;
	logic [15:0]        cmp_next_reg;
	logic [2:0]         sector_next_reg;
	logic [2:0]         sector_reg;
	logic [15:0]        sat_limit_reg;
	logic signed [15:0] sine_reg;
	logic signed [15:0] cosine_reg;
	logic signed [15:0] vd_req_reg;
	logic signed [15:0] vq_req_reg;
	logic [15:0]        lut [LUT_DEPTH_L];
	logic signed [15:0] ia_reg;
	logic signed [15:0] ib_reg;
	logic               recon_valid_reg;
	logic signed [15:0] alpha_reg;
	logic signed [15:0] beta_reg;
	logic               clarke_valid_reg;
	logic [31:0]        mag_sq_reg;
	logic signed [15:0] vd_sat_reg;
	logic signed [15:0] vq_sat_reg;
	logic [31:0]        rdata_next;
	logic [15:0]        cnt_sel;
	logic               up_sel;
	logic               load_evt;
	logic               start_v;
	logic               ctrl_wr;
	logic signed [15:0] q_rot;
	logic signed [15:0] d_rot;
	logic signed [15:0] va_rot;
	logic signed [15:0] vb_rot;
	logic signed [15:0] neg_sine;
	logic [31:0]        vd_sq;
	logic [31:0]        vq_sq;
	logic [31:0]        lim_sq;
	logic [15:0]        factor;
	logic signed [31:0] beta_prod;
	logic signed [17:0] beta_sum;
	logic signed [16:0] neg_sum;
	logic signed [32:0] vd_scaled;
	logic signed [32:0] vq_scaled;
	focss_pkg::focss_vstate_t vstate_reg;

	// Picks the converter channel pair that avoids the phase with the
	// shortest low-side on time; other topologies always read A and B.
	function automatic logic [1:0] pair_for(
		input logic [2:0] sector,
		input logic [1:0] topo
	);
		if (topo != focss_pkg::TOPO_THREE_SHUNT)
			return focss_pkg::PAIR_AB;
		else if (sector == 3'h1 || sector == 3'h6)
			return focss_pkg::PAIR_BC;
		else if (sector == 3'h2 || sector == 3'h3)
			return focss_pkg::PAIR_AC;
		else
			return focss_pkg::PAIR_AB;
	endfunction

	assign ctrl_wr = wr && addr == focss_pkg::ADDR_CTRL;
	assign start_v = wr && addr == focss_pkg::ADDR_VQ_REQ;

	// Timer source selection; in dual drive the converters follow the
	// timer whose update event came last, the first timer when both come in one cycle.
	assign cnt_sel = drive_sel ? second_timer_count : first_timer_count;
	assign up_sel = drive_sel ? second_timer_up : first_timer_up;
	assign load_evt = first_timer_update_event ||
		(dual_reg && second_timer_update_event);

	// Configuration registers written by software.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			topology_reg    <= focss_pkg::TOPO_THREE_SHUNT;
			dual_reg        <= 1'b0;
			after_next_reg  <= 1'b0;
			cmp_next_reg    <= focss_pkg::CMP_RST;
			sector_next_reg <= focss_pkg::SECTOR_RST;
			sat_limit_reg   <= focss_pkg::SAT_LIMIT_RST;
			sine_reg        <= 16'sh0000;
			cosine_reg      <= focss_pkg::WORD_MAX;
			vd_req_reg      <= 16'sh0000;
			vq_req_reg      <= 16'sh0000;
		end else if (wr) begin
			if (addr == focss_pkg::ADDR_CTRL) begin
				topology_reg <= wdata[focss_pkg::CTRL_TOPO_LSB +: 2];
				dual_reg <= wdata[focss_pkg::CTRL_DUAL_BIT];
				after_next_reg <= wdata[focss_pkg::CTRL_AFTER_BIT];
			end else if (addr == focss_pkg::ADDR_SAMPLE_CMP) begin
				cmp_next_reg <= wdata[15:0];
			end else if (addr == focss_pkg::ADDR_SECTOR) begin
				sector_next_reg <= wdata[2:0];
			end else if (addr == focss_pkg::ADDR_SAT_LIMIT) begin
				sat_limit_reg <= wdata[15:0];
			end else if (addr == focss_pkg::ADDR_SINE) begin
				sine_reg <= wdata[15:0];
			end else if (addr == focss_pkg::ADDR_COSINE) begin
				cosine_reg <= wdata[15:0];
			end else if (addr == focss_pkg::ADDR_VD_REQ) begin
				vd_req_reg <= wdata[15:0];
			end else if (addr == focss_pkg::ADDR_VQ_REQ) begin
				vq_req_reg <= wdata[15:0];
			end
		end
	end

	// Scaling factor table, filled by software for the chosen index.
	always_ff @(posedge clk) begin
		if (wr && addr[focss_pkg::LUT_SEL_BIT])
			lut[addr[2 +: focss_pkg::LUT_IDX_W]] <= wdata[15:0];
	end

	// The DMA pulse sets the enable; a control write with bit 4 set clears
	// it, and a pulse in the same cycle as the clear keeps it set.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			adc_trigger_enable <= 1'b0;
		else if (trigger_enable_dma_channel)
			adc_trigger_enable <= 1'b1;
		else if (ctrl_wr && wdata[focss_pkg::CTRL_TEN_CLR_BIT])
			adc_trigger_enable <= 1'b0;
	end

	// Per-period reload of compare value, polarity and channel pair.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sampling_compare_value <= focss_pkg::CMP_RST;
			trigger_polarity_bit   <= 1'b0;
			sector_reg             <= focss_pkg::SECTOR_RST;
			channel_pair           <= focss_pkg::PAIR_BC;
		end else if (load_evt) begin
			sampling_compare_value <= cmp_next_reg;
			trigger_polarity_bit <= after_next_reg;
			sector_reg <= sector_next_reg;
			channel_pair <= pair_for(sector_next_reg, topology_reg);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			drive_sel <= 1'b0;
		else if (!dual_reg)
			drive_sel <= 1'b0;
		else if (first_timer_update_event)
			drive_sel <= 1'b0;
		else if (second_timer_update_event)
			drive_sel <= 1'b1;
	end

	// Trigger channel: rises on the compare match in the chosen half of
	// the period and falls when the count direction turns, so one rising
	// edge starts both converters each period.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sampling_trigger_channel <= 1'b0;
		end else if (!trigger_polarity_bit) begin
			if (up_sel && cnt_sel == sampling_compare_value)
				sampling_trigger_channel <= 1'b1;
			else if (!up_sel)
				sampling_trigger_channel <= 1'b0;
		end else begin
			if (!up_sel && cnt_sel == sampling_compare_value)
				sampling_trigger_channel <= 1'b1;
			else if (up_sel)
				sampling_trigger_channel <= 1'b0;
		end
	end

	// Missing phase from the zero-sum relation of the three currents.
	assign neg_sum = -17'(master_converter_data) -
		17'(slave_converter_data);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ia_reg <= 16'sh0000;
			ib_reg <= 16'sh0000;
			recon_valid_reg <= 1'b0;
		end else begin
			recon_valid_reg <= conv_done;
			if (conv_done) begin
				if (channel_pair == focss_pkg::PAIR_BC) begin
					ia_reg <= focss_pkg::sat16(48'(neg_sum));
					ib_reg <= master_converter_data;
				end else if (channel_pair == focss_pkg::PAIR_AC) begin
					ia_reg <= master_converter_data;
					ib_reg <= focss_pkg::sat16(48'(neg_sum));
				end else begin
					ia_reg <= master_converter_data;
					ib_reg <= slave_converter_data;
				end
			end
		end
	end

	assign beta_sum = -(18'(ia_reg) + 18'(ib_reg) + 18'(ib_reg));
	assign beta_prod = 32'(beta_sum) * 32'(focss_pkg::INV_SQRT3);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alpha_reg <= 16'sh0000;
			beta_reg <= 16'sh0000;
			clarke_valid_reg <= 1'b0;
		end else begin
			clarke_valid_reg <= recon_valid_reg;
			if (recon_valid_reg) begin
				alpha_reg <= ia_reg;
				beta_reg <= focss_pkg::sat_q15(48'(beta_prod));
			end
		end
	end

	focss_rotate u_park (
		.x  (alpha_reg),
		.y  (beta_reg),
		.c  (cosine_reg),
		.s  (sine_reg),
		.o1 (q_rot),
		.o2 (d_rot)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			i_q <= 16'sh0000;
			i_d <= 16'sh0000;
			currents_valid <= 1'b0;
		end else begin
			currents_valid <= clarke_valid_reg;
			if (clarke_valid_reg) begin
				i_q <= q_rot;
				i_d <= d_rot;
			end
		end
	end

	// Circle limitation between the regulators and the inverse rotation.
	assign vd_sq = 32'(vd_req_reg) * 32'(vd_req_reg);
	assign vq_sq = 32'(vq_req_reg) * 32'(vq_req_reg);
	assign lim_sq = 32'(sat_limit_reg) * 32'(sat_limit_reg);
	assign factor = lut[mag_sq_reg[focss_pkg::MAG_IDX_LSB +:
		focss_pkg::LUT_IDX_W]];
	assign vd_scaled = 33'(vd_req_reg) * 33'($signed({1'b0, factor}));
	assign vq_scaled = 33'(vq_req_reg) * 33'($signed({1'b0, factor}));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			vstate_reg <= focss_pkg::V_IDLE;
		else
			case (vstate_reg)
			focss_pkg::V_IDLE: begin
				if (start_v)
					vstate_reg <= focss_pkg::V_MAG;
			end
			focss_pkg::V_MAG:   vstate_reg <= focss_pkg::V_SCALE;
			focss_pkg::V_SCALE: vstate_reg <= focss_pkg::V_ROT;
			default:            vstate_reg <= focss_pkg::V_IDLE;
			endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mag_sq_reg <= 32'h00000000;
			vd_sat_reg <= 16'sh0000;
			vq_sat_reg <= 16'sh0000;
		end else if (vstate_reg == focss_pkg::V_MAG) begin
			mag_sq_reg <= vd_sq + vq_sq;
		end else if (vstate_reg == focss_pkg::V_SCALE) begin
			if (mag_sq_reg > lim_sq) begin
				vd_sat_reg <= focss_pkg::sat_q15(48'(vd_scaled));
				vq_sat_reg <= focss_pkg::sat_q15(48'(vq_scaled));
			end else begin
				vd_sat_reg <= vd_req_reg;
				vq_sat_reg <= vq_req_reg;
			end
		end
	end

	// Negated sine turns the forward rotator into the inverse one.
	assign neg_sine = focss_pkg::sat16(-48'(sine_reg));

	focss_rotate u_inv_park (
		.x  (vq_sat_reg),
		.y  (vd_sat_reg),
		.c  (cosine_reg),
		.s  (neg_sine),
		.o1 (va_rot),
		.o2 (vb_rot)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			v_alpha <= 16'sh0000;
			v_beta <= 16'sh0000;
			voltages_valid <= 1'b0;
		end else begin
			voltages_valid <= vstate_reg == focss_pkg::V_ROT;
			if (vstate_reg == focss_pkg::V_ROT) begin
				v_alpha <= va_rot;
				v_beta <= vb_rot;
			end
		end
	end

	// Read decode; unmapped addresses read as zero.
	always_comb begin
		rdata_next = 32'h00000000;
		if (addr == focss_pkg::ADDR_CTRL)
			rdata_next = {27'h0000000, adc_trigger_enable, after_next_reg,
				dual_reg, topology_reg};
		else if (addr == focss_pkg::ADDR_SAMPLE_CMP)
			rdata_next = {16'h0000, cmp_next_reg};
		else if (addr == focss_pkg::ADDR_SECTOR)
			rdata_next = {29'h00000000, sector_next_reg};
		else if (addr == focss_pkg::ADDR_SAT_LIMIT)
			rdata_next = {16'h0000, sat_limit_reg};
		else if (addr == focss_pkg::ADDR_SINE)
			rdata_next = {16'h0000, sine_reg};
		else if (addr == focss_pkg::ADDR_COSINE)
			rdata_next = {16'h0000, cosine_reg};
		else if (addr == focss_pkg::ADDR_VD_REQ)
			rdata_next = {16'h0000, vd_req_reg};
		else if (addr == focss_pkg::ADDR_VQ_REQ)
			rdata_next = {16'h0000, vq_req_reg};
		else if (addr == focss_pkg::ADDR_IQD)
			rdata_next = {i_q, i_d};
		else if (addr == focss_pkg::ADDR_VAB)
			rdata_next = {v_alpha, v_beta};
		else if (addr == focss_pkg::ADDR_STATUS)
			rdata_next = {22'h000000, vstate_reg != focss_pkg::V_IDLE,
				drive_sel, sampling_trigger_channel, trigger_polarity_bit,
				channel_pair, 1'b0, sector_reg};
		else if (addr == focss_pkg::ADDR_IAB)
			rdata_next = {alpha_reg, beta_reg};
		else if (addr == focss_pkg::ADDR_VQD_SAT)
			rdata_next = {vq_sat_reg, vd_sat_reg};
		else if (addr[focss_pkg::LUT_SEL_BIT])
			rdata_next = {16'h0000, lut[addr[2 +: focss_pkg::LUT_IDX_W]]};
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rdata <= 32'h00000000;
		else if (rd)
			rdata <= rdata_next;
		else
			rdata <= 32'h00000000;
	end
endmodule // focss_core
`default_nettype wire

//--- sim/focss_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module focss_core_monitor (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [8:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic [15:0] first_timer_count,
	input wire logic        first_timer_up,
	input wire logic        first_timer_update_event,
	input wire logic [15:0] second_timer_count,
	input wire logic        second_timer_update_event,
	input wire logic        trigger_enable_dma_channel,
	input wire logic        conv_done,
	input wire logic        sampling_trigger_channel,
	input wire logic        trigger_polarity_bit,
	input wire logic [15:0] sampling_compare_value,
	input wire logic [1:0]  channel_pair,
	input wire logic        adc_trigger_enable,
	input wire logic        drive_sel,
	input wire logic        currents_valid,
	input wire logic        voltages_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_trig_up: assert property (
		!drive_sel && !trigger_polarity_bit && first_timer_up &&
		first_timer_count == sampling_compare_value
		|=> sampling_trigger_channel) else $error("no trigger on up match");
	a_trig_down: assert property (
		!drive_sel && trigger_polarity_bit && !first_timer_up &&
		first_timer_count == sampling_compare_value
		|=> sampling_trigger_channel) else $error("no trigger on down match");
	a_trig_cause: assert property (
		$rose(sampling_trigger_channel)
		|-> $past(drive_sel ? second_timer_count : first_timer_count) ==
		$past(sampling_compare_value))
		else $error("trigger rose without a compare match");
	a_current_lat: assert property (
		conv_done |-> ##3 currents_valid)
		else $error("currents not valid three cycles after conversion");
	a_voltage_lat: assert property (
		voltages_valid |-> $past(wr, 4) &&
		$past(addr, 4) == focss_pkg::ADDR_VQ_REQ)
		else $error("voltages valid without a request four cycles back");
	a_dma_set: assert property (
		trigger_enable_dma_channel |=> adc_trigger_enable)
		else $error("trigger enable not set by transfer pulse");
	a_enable_clear: assert property (
		wr && addr == focss_pkg::ADDR_CTRL &&
		wdata[focss_pkg::CTRL_TEN_CLR_BIT] &&
		!trigger_enable_dma_channel |=> !adc_trigger_enable)
		else $error("trigger enable not cleared by control write");
	a_period_hold: assert property (
		!first_timer_update_event && !second_timer_update_event
		|=> $stable(sampling_compare_value) && $stable(channel_pair) &&
		$stable(trigger_polarity_bit))
		else $error("sampling set changed between update events");
endmodule // focss_core_monitor
bind focss_core focss_core_monitor mon_u (
	.clk, .rstn, .addr, .wdata, .wr, .first_timer_count, .first_timer_up,
	.first_timer_update_event, .second_timer_count,
	.second_timer_update_event,
	.trigger_enable_dma_channel, .conv_done, .sampling_trigger_channel,
	.trigger_polarity_bit, .sampling_compare_value, .channel_pair,
	.adc_trigger_enable, .drive_sel, .currents_valid, .voltages_valid
);
`default_nettype wire

//--- sim/focss_pwm_adc.sv
`timescale 1ns/1ps
`default_nettype none
module focss_pwm_adc #(
	parameter int PER = 40
) (
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic               trig,
	input  wire logic               ten,
	input  wire logic [1:0]         pair,
	input  wire logic signed [15:0] ia,
	input  wire logic signed [15:0] ib,
	output logic [15:0]             cnt,
	output logic                    up,
	output logic                    upd,
	output logic                    done,
	output logic signed [15:0]      md,
	output logic signed [15:0]      sd
);
	logic               trig_q;
	logic [1:0]         wt;
	logic signed [15:0] ic;
	assign ic = -(ia + ib);
	// Centre-aligned counter; the update pulse marks the underflow.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 16'h0000;
			up <= 1'b1;
			upd <= 1'b0;
		end else begin
			upd <= !up && cnt == 16'h0001;
			cnt <= up ? cnt + 16'h0001 : cnt - 16'h0001;
			if (up && cnt == 16'(PER - 1))
				up <= 1'b0;
			else if (!up && cnt == 16'h0001)
				up <= 1'b1;
		end
	end
	// Data lines toggle outside a result so stale values never match.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trig_q <= 1'b0;
			wt <= 2'h0;
			done <= 1'b0;
			md <= 16'sh0000;
			sd <= 16'sh0000;
		end else begin
			trig_q <= trig;
			wt <= trig && !trig_q && ten ? 2'h3 :
				wt != 2'h0 ? wt - 2'h1 : 2'h0;
			done <= wt == 2'h1;
			md <= wt == 2'h1 ? (pair == 2'h0 ? ib : ia) : ~md;
			sd <= wt == 2'h1 ? (pair == 2'h2 ? ib : ic) : ~sd;
		end
	end
endmodule // focss_pwm_adc
`default_nettype wire

//--- sim/foc_transform_sample_sched_test.sv
`timescale 1ns/1ps
`default_nettype none
module foc_transform_sample_sched_test;
	logic               clk, rstn, wr, rd, u1, e1, u2, e2, dma, done;
	logic               trig, pol, ten, dsel, cv, vv;
	logic [8:0]         addr;
	logic [31:0]        wdata, rdata;
	logic [15:0]        c1, c2, cmp;
	logic [1:0]         pair;
	logic signed [15:0] md, sd, pia, pib, iq, id, va, vb;
	int                 fails = 0, checks = 0, cyc = 0, lut[64];
	focss_core dut_u (
		.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
		.first_timer_count(c1), .first_timer_up(u1),
		.first_timer_update_event(e1), .second_timer_count(c2),
		.second_timer_up(u2), .second_timer_update_event(e2),
		.trigger_enable_dma_channel(dma), .conv_done(done),
		.master_converter_data(md), .slave_converter_data(sd),
		.sampling_trigger_channel(trig), .trigger_polarity_bit(pol),
		.sampling_compare_value(cmp), .channel_pair(pair),
		.adc_trigger_enable(ten), .drive_sel(dsel), .i_q(iq), .i_d(id),
		.currents_valid(cv), .v_alpha(va), .v_beta(vb), .voltages_valid(vv)
	);
	focss_pwm_adc #(.PER(40)) pwm1_u (.clk, .rstn, .trig, .ten, .pair,
		.ia(pia), .ib(pib), .cnt(c1), .up(u1), .upd(e1), .done,
		.md, .sd);
	focss_pwm_adc #(.PER(27)) pwm2_u (.clk, .rstn, .trig(1'b0),
		.ten(1'b0), .pair(2'h0), .ia(pia), .ib(pib), .cnt(c2), .up(u2),
		.upd(e2), .done(), .md(), .sd());
	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [8:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_upd();
		do step(); while (e1 !== 1'b1);
		step();
	endtask
	function automatic int q15(input longint v);
		longint t = v >>> 15;
		return t > 32767 ? 32767 : t < -32768 ? -32768 : int'(t);
	endfunction
	function automatic void cmodel(input int a, input int b, input int s,
		input int c, output int q, output int d);
		int be;
		be = q15(-(longint'(a) + 2 * b) * int'(focss_pkg::INV_SQRT3));
		q = q15(longint'(a) * c - longint'(be) * s);
		d = q15(longint'(a) * s + longint'(be) * c);
	endfunction
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			finish_test();
		end
	end
	initial begin
		int q, d, sn, cs, vd, vq, lim, topo, aft, xp, sec;
		longint m2;
		logic [31:0] r;
		rstn = 1'b0;
		addr = 9'h000;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
		dma = 1'b0;
		pia = 16'sh0000;
		pib = 16'sh0000;
		void'($urandom(99544));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rreg(focss_pkg::ADDR_SAT_LIMIT, r);
		chk("sat_limit", r[15:0], 16'h7FFF);
		rreg(9'h0FC, r);
		chk("unmapped", r[15:0] | r[31:16], 16'h0000);
		for (int i = 0; i < 64; i++) begin
			lut[i] = 16384 + 200 * i;
			wreg(9'(256 + 4 * i), 32'(lut[i]));
		end
		@(posedge clk);
		dma <= 1'b1;
		@(posedge clk);
		dma <= 1'b0;
		#1 chk("trig_en", 16'(ten), 16'h0001);
		$display("setup test done");
		for (int k = 0; k < 8; k++) begin
			topo = k > 5 ? k - 5 : 0;
			aft = k < 2 ? k : $urandom % 2;
			xp = 10 + $urandom % 21;
			sn = int'($urandom % 46341) - 23170;
			cs = int'($urandom % 46341) - 23170;
			sec = 1 + $urandom % 6;
			wait_upd();
			wreg(focss_pkg::ADDR_SINE, 32'(sn));
			wreg(focss_pkg::ADDR_COSINE, 32'(cs));
			wreg(focss_pkg::ADDR_SECTOR, 32'(sec));
			wreg(focss_pkg::ADDR_SAMPLE_CMP, 32'(xp));
			wreg(focss_pkg::ADDR_CTRL, 32'(aft * 8 + topo));
			pia <= 16'(int'($urandom % 8001) - 4000);
			pib <= 16'(int'($urandom % 8001) - 4000);
			wait_upd();
			chk("compare", cmp, 16'(xp));
			chk("polarity", 16'(pol), 16'(aft));
			chk("pair", 16'(pair), topo != 0 ? 16'h2 :
				sec == 1 || sec == 6 ? 16'h0 : sec < 4 ? 16'h1 : 16'h2);
			do step(); while (cv !== 1'b1);
			cmodel(pia, pib, sn, cs, q, d);
			chk("i_q", iq, 16'(q));
			chk("i_d", id, 16'(d));
		end
		$display("current test done");
		for (int k = 0; k < 6; k++) begin
			lim = k < 2 ? 32767 : 28000 + 500 * k;
			vd = k == 0 ? -200 : int'($urandom % 65536) - 32768;
			vq = k == 0 ? 100 : int'($urandom % 65536) - 32768;
			wreg(focss_pkg::ADDR_SAT_LIMIT, 32'(lim));
			wreg(focss_pkg::ADDR_VD_REQ, 32'(vd));
			wreg(focss_pkg::ADDR_VQ_REQ, 32'(vq));
			do step(); while (vv !== 1'b1);
			m2 = longint'(vd) * vd + longint'(vq) * vq;
			if (m2 > longint'(lim) * lim) begin
				vd = q15(longint'(vd) * lut[(m2 >> 26) & 63]);
				vq = q15(longint'(vq) * lut[(m2 >> 26) & 63]);
			end
			chk("v_alpha", va,
				16'(q15(longint'(vq) * cs + longint'(vd) * sn)));
			chk("v_beta", vb,
				16'(q15(longint'(vd) * cs - longint'(vq) * sn)));
		end
		$display("voltage test done");
		wreg(focss_pkg::ADDR_CTRL, 32'h0000_0004);
		do step(); while (!(e2 === 1'b1 && e1 !== 1'b1));
		step();
		chk("drive_sel", 16'(dsel), 16'h0001);
		wait_upd();
		chk("drive_sel", 16'(dsel), 16'h0000);
		wreg(focss_pkg::ADDR_CTRL, 32'h0000_0010);
		step();
		chk("trig_en", 16'(ten), 16'h0000);
		$display("drive test done");
		finish_test();
	end
endmodule // foc_transform_sample_sched_test
`default_nettype wire
